// File: rtl/pmic_cfg_clock_intmask_regs.sv
module pmic_cfg_clock_intmask_regs
   import pmic_cfg_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic [IDX_W-1:0]  reg_index,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   input  wire logic [REG_W-1:0]  reg_wdata,
   output logic      [REG_W-1:0]  reg_rdata,
   output logic                   reg_unmapped,
   input  wire logic [7:0]        tsd_event,
   input  wire logic [6:0]        overcurrent_event,
   input  wire logic [15:0]       supply_event,
   output logic                   int_req,
   output logic      [7:0]        regulator_shutdown,
   output logic                   deep_fail_safe_state,
   output logic      [7:0]        die_temp_limit_c,
   output logic                   die_temp_valid,
   output logic      [4:0]        amux_channel_select,
   output logic      [5:0]        amux_ratio,
   output logic                   spread_enable,
   output logic                   spread_profile,
   output logic      [16:0]       spread_mod_hz,
   output logic      [2:0]        sync_in_divider,
   output logic                   sync_in_to_pll,
   output logic                   clk_out_source,
   output logic      [2:0]        clk_out_delay,
   output logic      [3:0]        clk_out_mux,
   output logic      [3:0]        osc_freq_trim,
   output logic      [9:0]        low_power_clk_khz
);

   logic [REG_W-1:0] tsd_cfg;
   logic [REG_W-1:0] amux_cfg;
   logic [REG_W-1:0] clk_pri;
   logic [REG_W-1:0] clk_lp;
   logic [REG_W-1:0] mask_reg;
   logic [REG_W-1:0] mask_sup;
   logic [REG_W-1:0] flag_reg;
   logic [REG_W-1:0] flag_sup;
   logic [REG_W-1:0] next_flag_reg;
   logic [REG_W-1:0] next_flag_sup;
   logic [REG_W-1:0] clr_reg;
   logic [REG_W-1:0] clr_sup;
   logic [REG_W-1:0] ev_reg;
   logic [REG_W-1:0] ev_sup;
   logic [EV_W-1:0]  ev_sync;
   logic [7:0]       tsd_live;
   logic [2:0]       temp_code;
   logic             unmasked_any;

   // Analog comparator levels arrive from outside this clock domain
   sync3 #(
      .W (EV_W)
   ) u_event_sync (
      .sys_clk (sys_clk),
      .reset   (reset),
      .d       ({supply_event, overcurrent_event, tsd_event}),
      .q       (ev_sync)
   );

   // Event vectors laid out bit for bit like the two mask registers
   assign tsd_live = ev_sync[7:0];
   // Thermal inputs come in reaction-bit order; the flag byte keeps the
   // HV linear regulator on top, so input bit 0 moves to flag bit 7
   assign ev_reg   = {ev_sync[14], 1'b0, ev_sync[13:8],
                      ev_sync[0], ev_sync[7:1]};
   assign ev_sup   = ev_sync[30:15];

   assign temp_code = tsd_cfg[DIE_TEMP_LSB +: 3];

   // Configuration and mask registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tsd_cfg  <= RST_TSD_CFG;
         amux_cfg <= RST_AMUX;
         clk_pri  <= RST_CLK_PRI;
         clk_lp   <= RST_CLK_LP;
         mask_reg <= RST_MASK;
         mask_sup <= RST_MASK;
      end else if (reg_write) begin
         case (reg_index)
            IDX_TSD_CFG: begin
               tsd_cfg <= reg_wdata & WMASK_TSD_CFG;
            end
            IDX_AMUX: begin
               amux_cfg <= reg_wdata & WMASK_AMUX;
            end
            IDX_CLK_PRI: begin
               clk_pri <= reg_wdata & WMASK_CLK_PRI;
            end
            IDX_CLK_LP: begin
               clk_lp <= reg_wdata & WMASK_CLK_LP;
            end
            IDX_MASK_REG: begin
               mask_reg <= reg_wdata & WMASK_REG_EV;
            end
            IDX_MASK_SUP: begin
               mask_sup <= reg_wdata & WMASK_SUP_EV;
            end
            default: begin
            end
         endcase
      end
   end

   // Write-one-to-clear strobes for the flag registers
   always_comb begin
      clr_reg = '0;
      clr_sup = '0;
      if (reg_write && reg_index == IDX_FLAG_REG) begin
         clr_reg = reg_wdata;
      end
      if (reg_write && reg_index == IDX_FLAG_SUP) begin
         clr_sup = reg_wdata;
      end
   end

   // An event in the clearing cycle survives: set beats clear
   always_comb begin
      next_flag_reg = ((flag_reg & ~clr_reg) | ev_reg) & WMASK_REG_EV;
      next_flag_sup = ((flag_sup & ~clr_sup) | ev_sup) & WMASK_SUP_EV;
   end

   // Flags record whatever the masks say
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         flag_reg <= RST_FLAG;
         flag_sup <= RST_FLAG;
      end else begin
         flag_reg <= next_flag_reg;
         flag_sup <= next_flag_sup;
      end
   end

   assign unmasked_any = |(flag_reg & ~mask_reg) | |(flag_sup & ~mask_sup);

   // Interrupt request
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         int_req <= 1'b0;
      end else begin
         int_req <= unmasked_any;
      end
   end

   // Read port; the write-only sync bit reads back as zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         case (reg_index)
            IDX_TSD_CFG:  reg_rdata <= tsd_cfg;
            IDX_AMUX:     reg_rdata <= amux_cfg;
            IDX_CLK_PRI:  reg_rdata <= clk_pri & RMASK_CLK_PRI;
            IDX_CLK_LP:   reg_rdata <= clk_lp;
            IDX_MASK_REG: reg_rdata <= mask_reg;
            IDX_MASK_SUP: reg_rdata <= mask_sup;
            IDX_FLAG_REG: reg_rdata <= flag_reg;
            IDX_FLAG_SUP: reg_rdata <= flag_sup;
            default:      reg_rdata <= '0;
         endcase
      end
   end

   // Unmapped access: one-cycle pulse, writes dropped, reads give zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_unmapped <= 1'b0;
      end else begin
         reg_unmapped <= (reg_write || reg_read) &&
                         (reg_index > IDX_FLAG_SUP);
      end
   end

   // Thermal shutdown reaction
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         regulator_shutdown   <= '0;
         deep_fail_safe_state <= 1'b0;
      end else begin
         regulator_shutdown   <= tsd_live;
         deep_fail_safe_state <= |(tsd_live & tsd_cfg[7:0]);
      end
   end

   // Die-centre threshold; codes above the last step hold the old value
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         die_temp_limit_c <= 8'(TEMP_BASE_C);
         die_temp_valid   <= 1'b1;
      end else if (temp_code <= TEMP_CODE_MAX) begin
         die_temp_limit_c <= 8'(TEMP_BASE_C +
                                TEMP_STEP_C * int'(temp_code));
         die_temp_valid   <= 1'b1;
      end else begin
         die_temp_valid   <= 1'b0;
      end
   end

   // Analog mux
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         amux_channel_select <= '0;
         amux_ratio          <= AMUX_RATIO_LO;
      end else begin
         amux_channel_select <= amux_cfg[4:0];
         amux_ratio          <= amux_cfg[RATIO_BIT] ? AMUX_RATIO_HI
                                                    : AMUX_RATIO_LO;
      end
   end

   // Spread spectrum and input sync
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         spread_enable   <= 1'b0;
         spread_profile  <= 1'b0;
         spread_mod_hz   <= SPREAD_LO_HZ;
         sync_in_divider <= SYNC_DIV_LO;
         sync_in_to_pll  <= 1'b0;
      end else begin
         spread_enable   <= clk_pri[SPREAD_EN_BIT];
         spread_profile  <= clk_pri[SPREAD_PRF_BIT];
         spread_mod_hz   <= clk_pri[SPREAD_PRF_BIT] ? SPREAD_HI_HZ
                                                    : SPREAD_LO_HZ;
         sync_in_divider <= clk_pri[SYNC_DIV_BIT] ? SYNC_DIV_HI
                                                  : SYNC_DIV_LO;
         sync_in_to_pll  <= clk_pri[SYNC_PLL_BIT];
      end
   end

   // Output clock selection; the delay itself is counted in the PLL
   // domain, so only the count leaves here
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         clk_out_source <= 1'b0;
         clk_out_delay  <= '0;
         clk_out_mux    <= '0;
         osc_freq_trim  <= '0;
      end else begin
         clk_out_source <= clk_pri[CLK_SRC_BIT];
         clk_out_delay  <= clk_pri[CLK_DLY_LSB +: 3];
         clk_out_mux    <= clk_pri[CLK_MUX_LSB +: 4];
         osc_freq_trim  <= clk_pri[3:0];
      end
   end

   // Low-power clock frequency
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         low_power_clk_khz <= LP_KHZ_100;
      end else begin
         case (clk_lp[1:0])
            LP_SEL_300: low_power_clk_khz <= LP_KHZ_300;
            LP_SEL_600: low_power_clk_khz <= LP_KHZ_600;
            default:    low_power_clk_khz <= LP_KHZ_100;
         endcase
      end
   end

   a_int_raised: assert property (
      @(posedge sys_clk) disable iff (reset)
      unmasked_any |=> int_req)
      else $error("Unmasked flag did not raise interrupt");

   a_int_masked: assert property (
      @(posedge sys_clk) disable iff (reset)
      (flag_reg != '0 && (flag_reg & ~mask_reg) == '0 &&
       (flag_sup & ~mask_sup) == '0)
      |=> !int_req)
      else $error("Masked flag raised interrupt");

   a_flag_sticky: assert property (
      @(posedge sys_clk) disable iff (reset)
      1'b1 |=> (($past(flag_reg) & ~$past(clr_reg) & ~flag_reg) == '0))
      else $error("Flag cleared without write of one");

   a_set_wins: assert property (
      @(posedge sys_clk) disable iff (reset)
      (ev_sup != '0) |=> ((flag_sup & $past(ev_sup)) == $past(ev_sup)))
      else $error("Event lost in flag register");

   a_fail_safe: assert property (
      @(posedge sys_clk) disable iff (reset)
      (tsd_live != '0) |=>
      (deep_fail_safe_state == |($past(tsd_live) & $past(tsd_cfg[7:0]))))
      else $error("Fail-safe request wrong for thermal event");

   a_temp_step: assert property (
      @(posedge sys_clk) disable iff (reset)
      (reg_write && reg_index == IDX_TSD_CFG &&
       reg_wdata[DIE_TEMP_LSB +: 3] == TEMP_CODE_MAX)
      |=> ##1 (die_temp_limit_c == 8'd150 && die_temp_valid))
      else $error("Top threshold code not 150C");

   a_ratio_sel: assert property (
      @(posedge sys_clk) disable iff (reset)
      (reg_write && reg_index == IDX_AMUX)
      |=> ##1 (amux_ratio == ($past(reg_wdata[RATIO_BIT], 2) ? 6'd34
                                                             : 6'd20)))
      else $error("Analog mux ratio does not follow write");

   a_sync_hidden: assert property (
      @(posedge sys_clk) disable iff (reset)
      (reg_read && reg_index == IDX_CLK_PRI) |=> !reg_rdata[SYNC_PLL_BIT])
      else $error("Write-only sync bit read back");

   a_sync_div: assert property (
      @(posedge sys_clk) disable iff (reset)
      $rose(clk_pri[SYNC_DIV_BIT]) |=> (sync_in_divider == 3'd6))
      else $error("Sync divider not six");

   a_lp_clock: assert property (
      @(posedge sys_clk) disable iff (reset)
      (clk_lp[1:0] == 2'h1) |=> (low_power_clk_khz == 10'd100))
      else $error("Low-power code 01 not 100 kHz");

   a_spread_rate: assert property (
      @(posedge sys_clk) disable iff (reset)
      clk_pri[SPREAD_PRF_BIT] |=> (spread_mod_hz == 17'd92600))
      else $error("Spread profile rate wrong");

   a_flag_map: assert property (
      @(posedge sys_clk) disable iff (reset)
      tsd_live[0] |=> flag_reg[7])
      else $error("HV linear thermal event not on flag bit 7");

   a_shutdown_live: assert property (
      @(posedge sys_clk) disable iff (reset)
      (tsd_live != '0) |=> (regulator_shutdown == $past(tsd_live)))
      else $error("Regulator shutdown does not follow thermal event");

   a_out_source: assert property (
      @(posedge sys_clk) disable iff (reset)
      clk_pri[CLK_SRC_BIT] |=> clk_out_source)
      else $error("Output clock source not second clock");

endmodule : pmic_cfg_clock_intmask_regs

// File: rtl/pmic_cfg_pkg.sv
package pmic_cfg_pkg;

   localparam int REG_W = 16;
   localparam int IDX_W = 4;
   localparam int EV_W  = 31;

   // Register indices on the register access port
   localparam logic [IDX_W-1:0] IDX_TSD_CFG  = 4'h0;
   localparam logic [IDX_W-1:0] IDX_AMUX     = 4'h1;
   localparam logic [IDX_W-1:0] IDX_CLK_PRI  = 4'h2;
   localparam logic [IDX_W-1:0] IDX_CLK_LP   = 4'h3;
   localparam logic [IDX_W-1:0] IDX_MASK_REG = 4'h4;
   localparam logic [IDX_W-1:0] IDX_MASK_SUP = 4'h5;
   localparam logic [IDX_W-1:0] IDX_FLAG_REG = 4'h6;
   localparam logic [IDX_W-1:0] IDX_FLAG_SUP = 4'h7;

   // Values after reset
   localparam logic [REG_W-1:0] RST_TSD_CFG  = 16'h0000;
   localparam logic [REG_W-1:0] RST_AMUX     = 16'h0000;
   localparam logic [REG_W-1:0] RST_CLK_PRI  = 16'h0000;
   localparam logic [REG_W-1:0] RST_CLK_LP   = 16'h0000;
   localparam logic [REG_W-1:0] RST_MASK     = 16'h0000;
   localparam logic [REG_W-1:0] RST_FLAG     = 16'h0000;

   // Implemented bits of each register
   localparam logic [REG_W-1:0] WMASK_TSD_CFG = 16'h07FF;
   localparam logic [REG_W-1:0] WMASK_AMUX    = 16'h003F;
   localparam logic [REG_W-1:0] WMASK_CLK_PRI = 16'hFFFF;
   localparam logic [REG_W-1:0] RMASK_CLK_PRI = 16'hFFBF;
   localparam logic [REG_W-1:0] WMASK_CLK_LP  = 16'h0003;
   localparam logic [REG_W-1:0] WMASK_REG_EV  = 16'hBFFF;
   localparam logic [REG_W-1:0] WMASK_SUP_EV  = 16'hFFFF;

   // Field positions
   localparam int DIE_TEMP_LSB   = 8;
   localparam int RATIO_BIT      = 5;
   localparam int SPREAD_PRF_BIT = 15;
   localparam int CLK_MUX_LSB    = 11;
   localparam int CLK_DLY_LSB    = 8;
   localparam int CLK_SRC_BIT    = 7;
   localparam int SYNC_PLL_BIT   = 6;
   localparam int SYNC_DIV_BIT   = 5;
   localparam int SPREAD_EN_BIT  = 4;

   // Die-centre threshold code
   localparam int             TEMP_BASE_C   = 75;
   localparam int             TEMP_STEP_C   = 15;
   localparam logic [2:0]     TEMP_CODE_MAX = 3'h5;

   // Divider and clock figures
   localparam logic [5:0]  AMUX_RATIO_LO  = 6'd20;
   localparam logic [5:0]  AMUX_RATIO_HI  = 6'd34;
   localparam logic [2:0]  SYNC_DIV_LO    = 3'd1;
   localparam logic [2:0]  SYNC_DIV_HI    = 3'd6;
   localparam logic [16:0] SPREAD_LO_HZ   = 17'd23150;
   localparam logic [16:0] SPREAD_HI_HZ   = 17'd92600;
   localparam logic [1:0]  LP_SEL_300     = 2'h2;
   localparam logic [1:0]  LP_SEL_600     = 2'h3;
   localparam logic [9:0]  LP_KHZ_100     = 10'd100;
   localparam logic [9:0]  LP_KHZ_300     = 10'd300;
   localparam logic [9:0]  LP_KHZ_600     = 10'd600;

endpackage : pmic_cfg_pkg

// File: rtl/sync3.sv
module sync3 #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // First stage feeds only the second; the filter looks at 2 and 3
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A bit moves only once stages two and three agree
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= (s2 & s3) | ((s2 ^ s3) & q);
      end
   end

endmodule : sync3

// File: bench/pmic_host_model.sv
module pmic_host_model
   import pmic_cfg_pkg::*;
(
   input  wire logic              sys_clk,
   output logic      [IDX_W-1:0]  reg_index,
   output logic                   reg_write,
   output logic                   reg_read,
   output logic      [REG_W-1:0]  reg_wdata,
   input  wire logic [REG_W-1:0]  reg_rdata,
   input  wire logic              reg_unmapped
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      reg_index = '0;
      reg_write = 1'b0;
      reg_read  = 1'b0;
      reg_wdata = '0;
   end

   // Strobe lowered on the next edge, so two accesses never merge
   task automatic write_reg(input logic [IDX_W-1:0] idx,
                            input logic [REG_W-1:0] data);
      @(posedge sys_clk);
      reg_index <= idx;
      reg_wdata <= data;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      // Wdata left driven with a changed value after the access
      reg_wdata <= ~data;
   endtask : write_reg

   task automatic read_reg(input  logic [IDX_W-1:0] idx,
                           output logic [REG_W-1:0] data,
                           output logic             unm);
      @(posedge sys_clk);
      reg_index <= idx;
      reg_read  <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1;
      data = reg_rdata;
      unm  = reg_unmapped;
   endtask : read_reg

   task automatic clear_flags();
      write_reg(IDX_FLAG_REG, 16'hFFFF);
      write_reg(IDX_FLAG_SUP, 16'hFFFF);
   endtask : clear_flags

endmodule : pmic_host_model

// File: bench/pmic_cfg_clock_intmask_regs_tb_top.sv
module pmic_cfg_clock_intmask_regs_tb_top
   import pmic_cfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic             sys_clk, reset, reg_write, reg_read, reg_unmapped;
   logic [IDX_W-1:0] reg_index;
   logic [REG_W-1:0] reg_wdata, reg_rdata, rd;
   logic             unm, int_req, deep_fail_safe_state, die_temp_valid;
   logic [7:0]       tsd_event, regulator_shutdown, die_temp_limit_c;
   logic [6:0]       overcurrent_event;
   logic [15:0]      supply_event;
   logic [4:0]       amux_channel_select;
   logic [5:0]       amux_ratio;
   logic             spread_enable, spread_profile, sync_in_to_pll;
   logic             clk_out_source;
   logic [16:0]      spread_mod_hz;
   logic [2:0]       sync_in_divider, clk_out_delay;
   logic [3:0]       clk_out_mux, osc_freq_trim;
   logic [9:0]       low_power_clk_khz;
   int               failures, total_checks;
   logic [REG_W-1:0] rmask [6] = '{WMASK_TSD_CFG, WMASK_AMUX, RMASK_CLK_PRI,
                                   WMASK_CLK_LP, WMASK_REG_EV, WMASK_SUP_EV};
   logic [9:0]       lp_exp [4] = '{LP_KHZ_100, LP_KHZ_100, LP_KHZ_300,
                                    LP_KHZ_600};

   pmic_host_model u_pmic_host_model (
      .sys_clk(sys_clk), .reg_index(reg_index), .reg_write(reg_write),
      .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_unmapped(reg_unmapped));

   pmic_cfg_clock_intmask_regs u_pmic_cfg_clock_intmask_regs (
      .sys_clk(sys_clk), .reset(reset), .reg_index(reg_index),
      .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_unmapped(reg_unmapped),
      .tsd_event(tsd_event), .overcurrent_event(overcurrent_event),
      .supply_event(supply_event), .int_req(int_req),
      .regulator_shutdown(regulator_shutdown),
      .deep_fail_safe_state(deep_fail_safe_state),
      .die_temp_limit_c(die_temp_limit_c), .die_temp_valid(die_temp_valid),
      .amux_channel_select(amux_channel_select), .amux_ratio(amux_ratio),
      .spread_enable(spread_enable), .spread_profile(spread_profile),
      .spread_mod_hz(spread_mod_hz), .sync_in_divider(sync_in_divider),
      .sync_in_to_pll(sync_in_to_pll), .clk_out_source(clk_out_source),
      .clk_out_delay(clk_out_delay), .clk_out_mux(clk_out_mux),
      .osc_freq_trim(osc_freq_trim), .low_power_clk_khz(low_power_clk_khz));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [16:0] exp,
                        input logic [16:0] got);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [15:0] d);
      u_pmic_host_model.write_reg(idx, d);
   endtask : wr

   task automatic rd_chk(input logic [IDX_W-1:0] idx,
                         input logic [REG_W-1:0] exp);
      u_pmic_host_model.read_reg(idx, rd, unm);
      check("reg_rdata", exp, rd);
      check("reg_unmapped", idx > 4'h7, unm);
   endtask : rd_chk

   task automatic end_sim();
      $display("Checks: %0d, failures: %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      end_sim();
   end

   initial begin
      reset = 1'b1;
      tsd_event = '0;
      overcurrent_event = '0;
      supply_event = '0;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      settle(1);
      check("limit", 75, die_temp_limit_c);
      check("ratio", 20, amux_ratio);
      check("spread hz", 23150, spread_mod_hz);
      check("divider", 1, sync_in_divider);
      check("lp khz", 100, low_power_clk_khz);
      for (int i = 0; i < 16; i++) begin
         rd_chk(i[IDX_W-1:0], 16'h0000);
      end
      for (int i = 0; i < 6; i++) begin
         wr(i[IDX_W-1:0], 16'hFFFF);
         rd_chk(i[IDX_W-1:0], rmask[i]);
      end
      wr(4'h8, 16'hFFFF);
      rd_chk(4'h8, 16'h0000);
      settle(1);
      check("spread en", 1, spread_enable);
      check("spread hz", 92600, spread_mod_hz);
      check("spread prf", 1, spread_profile);
      check("divider", 6, sync_in_divider);
      check("sync to pll", 1, sync_in_to_pll);
      check("out source", 1, clk_out_source);
      check("out delay", 7, clk_out_delay);
      check("mux trim", 8'hFF, {clk_out_mux, osc_freq_trim});
      check("ratio", 34, amux_ratio);
      check("channel", 5'h1F, amux_channel_select);
      check("temp valid", 0, die_temp_valid);
      for (int c = 0; c < 6; c++) begin
         wr(IDX_TSD_CFG, {5'h00, c[2:0], 8'h00});
         settle(2);
         check("limit", 75 + 15 * c, die_temp_limit_c);
         check("temp valid", 1, die_temp_valid);
      end
      for (int k = 0; k < 4; k++) begin
         wr(IDX_CLK_LP, {14'h0000, k[1:0]});
         settle(2);
         check("lp khz", lp_exp[k], low_power_clk_khz);
      end
      wr(IDX_CLK_PRI, 16'h0000);
      wr(IDX_MASK_REG, 16'h0000);
      wr(IDX_MASK_SUP, 16'h0000);
      wr(IDX_TSD_CFG, 16'h00AA);
      settle(2);
      check("out delay", 0, clk_out_delay);
      check("out source", 0, clk_out_source);
      check("spread en", 0, spread_enable);
      check("spread prf", 0, spread_profile);
      check("spread hz", 23150, spread_mod_hz);
      check("divider", 1, sync_in_divider);
      check("sync to pll", 0, sync_in_to_pll);
      // Odd regulators also request the fail-safe state
      for (int i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         tsd_event <= 8'h01 << i;
         settle(7);
         check("shutdown", 8'h01 << i, regulator_shutdown);
         check("fail safe", i % 2, deep_fail_safe_state);
         check("int_req", 1, int_req);
         // Input bit 0 is the HV linear regulator, flag bit 7
         rd_chk(IDX_FLAG_REG, 16'h0001 << ((i + 7) % 8));
         tsd_event <= 8'h00;
         settle(5);
         u_pmic_host_model.clear_flags();
         settle(2);
         check("int_req", 0, int_req);
      end
      wr(IDX_MASK_REG, WMASK_REG_EV);
      wr(IDX_MASK_SUP, WMASK_SUP_EV);
      @(posedge sys_clk);
      tsd_event <= 8'hFF;
      overcurrent_event <= 7'h7F;
      supply_event <= 16'hFFFF;
      settle(7);
      check("int_req masked", 0, int_req);
      rd_chk(IDX_FLAG_REG, WMASK_REG_EV);
      u_pmic_host_model.clear_flags();
      rd_chk(IDX_FLAG_SUP, 16'hFFFF);
      for (int r = 4; r < 6; r++) begin
         for (int b = 0; b < 16; b++) begin
            if (rmask[r][b]) begin
               wr(r[IDX_W-1:0], rmask[r] & ~(16'h0001 << b));
               settle(2);
               check("unmasked", 1, int_req);
               wr(r[IDX_W-1:0], rmask[r]);
               settle(2);
               check("masked", 0, int_req);
            end
         end
      end
      tsd_event <= 8'h00;
      overcurrent_event <= 7'h00;
      supply_event <= 16'h0000;
      settle(5);
      u_pmic_host_model.clear_flags();
      wr(IDX_MASK_REG, 16'h0000);
      wr(IDX_MASK_SUP, 16'h0000);
      settle(2);
      check("int_req idle", 0, int_req);
      rd_chk(IDX_FLAG_SUP, 16'h0000);
      end_sim();
   end

endmodule : pmic_cfg_clock_intmask_regs_tb_top
